// *** rec_pkg.sv ***
// Package for the receive error counter register bank.
// Holds register indexes, bit positions, reset values and the channel encoding.
package rec_pkg;
    // Register indexes; byte address on the bus is four times the index
    localparam logic [9:0] REC_IDX_CTRL = 10'h120;
    localparam logic [9:0] REC_IDX_STICKY = 10'h12a;
    localparam logic [9:0] REC_IDX_IRQ_EN = 10'h12e;
    localparam logic [9:0] REC_IDX_FRAMING_CNT = 10'h134;
    localparam logic [9:0] REC_IDX_PBIT_CNT = 10'h136;
    localparam logic [9:0] REC_IDX_FAR_BLOCK_CNT = 10'h138;
    localparam logic [9:0] REC_IDX_CBIT_CNT = 10'h13a;
    // Control register fields
    localparam int REC_CTRL_M23_BIT = 0;
    localparam int REC_CTRL_CRIT_LSB = 8;
    localparam logic [15:0] REC_CTRL_RESET = 16'h0000;
    // Sticky flag and enable layout: error flags at 8 + channel, count flags at channel
    localparam int REC_ERR_BASE = 8;
    localparam int REC_CNT_BASE = 0;
    localparam int REC_NUM_CHAN = 4;
    localparam logic [15:0] REC_FLAG_MASK = 16'h0f0f;
    localparam logic [15:0] REC_IRQ_EN_RESET = 16'h0000;
    localparam logic [15:0] REC_COUNT_RESET = 16'h0000;
    localparam logic [15:0] REC_COUNT_MAX = 16'hffff;
    // Channel order
    localparam int REC_CH_FRAMING = 0;
    localparam int REC_CH_PBIT = 1;
    localparam int REC_CH_FAR_BLOCK = 2;
    localparam int REC_CH_CBIT = 3;
    typedef enum logic [1:0] {
        REC_CRIT_0 = 2'b00,
        REC_CRIT_1 = 2'b01,
        REC_CRIT_2 = 2'b10,
        REC_CRIT_3 = 2'b11
    } rec_crit_e;
endpackage

// *** rec_err_chan.sv ***
// One error channel: accumulator, count register, error and count-change flags.
// Assumes event pulses and the update pulse come from logic on the same clock.
`timescale 1ns/1ns
module rec_err_chan (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_clk_en,
    input wire logic i_evt,
    input wire logic i_inhibit,
    input wire logic i_update,
    input wire logic i_clr_err,
    input wire logic i_clr_cnt,
    output logic [15:0] o_count,
    output logic o_err_sticky,
    output logic o_cnt_sticky
);
    typedef struct packed {
        logic [15:0] acc;
        logic [15:0] count;
        logic err_sticky;
        logic cnt_sticky;
    } rec_chan_s;

    rec_chan_s st_reg;
    rec_chan_s st_next;
    logic evt_ok;
    logic [15:0] acc_inc;

    always_comb begin
        evt_ok = i_evt && !i_inhibit;
        acc_inc = (st_reg.acc == rec_pkg::REC_COUNT_MAX) ? st_reg.acc
            : 16'(st_reg.acc + {15'h0000, evt_ok});
        st_next = st_reg;
        st_next.acc = acc_inc;
        if (i_update) begin
            // Hand the tally over and restart, counting a same-cycle event once
            st_next.count = acc_inc;
            st_next.acc = rec_pkg::REC_COUNT_RESET;
            if (acc_inc != 16'h0000 && st_reg.count == 16'h0000) begin
                st_next.cnt_sticky = 1'b1;
            end else if (i_clr_cnt) begin
                st_next.cnt_sticky = 1'b0;
            end
        end else if (i_clr_cnt) begin
            st_next.cnt_sticky = 1'b0;
        end
        if (evt_ok) begin
            st_next.err_sticky = 1'b1;
        end else if (i_clr_err) begin
            st_next.err_sticky = 1'b0;
        end
        if (i_inhibit) begin
            st_next.err_sticky = 1'b0;
            st_next.cnt_sticky = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_reg <= '0;
        end else if (i_clk_en) begin
            st_reg <= st_next;
        end
    end

    assign o_count = st_reg.count;
    assign o_err_sticky = st_reg.err_sticky;
    assign o_cnt_sticky = st_reg.cnt_sticky;

    a_count_hold: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        !(i_clk_en && i_update) |=> $stable(st_reg.count))
        else $error("count changed without update");
    a_count_load: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_clk_en && i_update && !i_inhibit && !i_evt && st_reg.acc != rec_pkg::REC_COUNT_MAX)
        |=> (st_reg.count == $past(st_reg.acc)) && (st_reg.acc == 16'h0000))
        else $error("accumulator not transferred on update");
    a_m23_quiet: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_clk_en && i_inhibit) |=> !st_reg.err_sticky && !st_reg.cnt_sticky)
        else $error("flag set while inhibited");
    a_m23_nocount: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_clk_en && i_inhibit && !i_update) |=> $stable(st_reg.acc))
        else $error("accumulator moved while inhibited");
endmodule // rec_err_chan

// *** rec_bank.sv ***
// Contract
// - P-bit error enable bit 9 passes its flag to the interrupt when global enable set.
// - Framing error enable bit 8 passes its flag to the interrupt when global enable set.
// - C-bit count enable bit 3 passes its change flag to the interrupt when global enable set.
// - Far-end block count enable bit 2 passes its change flag to the interrupt when global enable set.
// - P-bit count enable bit 1 passes its change flag to the interrupt when global enable set.
// - Framing count enable bit 0 passes its change flag to the interrupt when global enable set.
// - Framing error count register shows a 16-bit count of framing errors.
// - P-bit count register shows a 16-bit count of P-bit parity errors.
// - Far-end block count register shows a 16-bit count of far-end block errors.
// - C-bit count register shows a 16-bit count of C-bit parity errors.
// - In M23 mode far-end block and C-bit counters do not increment.
// - Count registers change only on the performance-monitor update pulse.
// - Framing error flag sets on the event chosen by the framing criterion.
// - P-bit parity error flag sets on every P-bit parity error.
// - Each count-change flag sets when its count goes from zero to nonzero.
// - In M23 mode C-bit and far-end block flags and count flags stay zero.
// Top of the receive error counter bank with APB register access.
// Assumes error events and the update pulse are one-cycle pulses on i_clk_sys.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ns
module rec_bank (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_clk_en,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [3:0] i_framing_evt,
    input wire logic i_pbit_parity_evt,
    input wire logic i_far_block_evt,
    input wire logic i_cbit_parity_evt,
    input wire logic i_perf_monitor_update,
    input wire logic i_port_status_irq_en_global,
    output logic o_irq
);
    typedef struct packed {
        logic m23_mode;
        logic [1:0] framing_err_criterion;
        logic [15:0] irq_en;
        logic [31:0] prdata;
        logic pslverr;
        logic irq;
    } rec_bank_s;

    rec_bank_s st_reg;
    rec_bank_s st_next;
    logic [9:0] idx;
    logic addr_ok;
    logic setup;
    logic wr;
    logic [15:0] wmask;
    logic [15:0] wdata;
    logic [15:0] sticky;
    logic [15:0] clr;
    logic [15:0] cnt_val [rec_pkg::REC_NUM_CHAN];
    logic [rec_pkg::REC_NUM_CHAN-1:0] evt;
    logic [rec_pkg::REC_NUM_CHAN-1:0] inhibit;
    logic [rec_pkg::REC_NUM_CHAN-1:0] err_flag;
    logic [rec_pkg::REC_NUM_CHAN-1:0] cnt_flag;
    logic [15:0] rd_word;

    assign idx = i_paddr[11:2];
    assign setup = i_psel && !i_penable;
    assign wr = i_psel && i_penable && i_pwrite;
    assign wmask = {{8{i_pstrb[1]}}, {8{i_pstrb[0]}}};
    assign wdata = i_pwdata[15:0] & wmask;
    assign o_pready = 1'b1;

    always_comb begin
        unique case (idx)
            rec_pkg::REC_IDX_CTRL,
            rec_pkg::REC_IDX_STICKY,
            rec_pkg::REC_IDX_IRQ_EN,
            rec_pkg::REC_IDX_FRAMING_CNT,
            rec_pkg::REC_IDX_PBIT_CNT,
            rec_pkg::REC_IDX_FAR_BLOCK_CNT,
            rec_pkg::REC_IDX_CBIT_CNT: addr_ok = (i_paddr[1:0] == 2'b00);
            default: addr_ok = 1'b0;
        endcase
    end

    // Framing criterion picks which framing event counts
    always_comb begin
        evt[rec_pkg::REC_CH_FRAMING] = i_framing_evt[st_reg.framing_err_criterion];
        evt[rec_pkg::REC_CH_PBIT] = i_pbit_parity_evt;
        evt[rec_pkg::REC_CH_FAR_BLOCK] = i_far_block_evt;
        evt[rec_pkg::REC_CH_CBIT] = i_cbit_parity_evt;
        inhibit = '0;
        inhibit[rec_pkg::REC_CH_FAR_BLOCK] = st_reg.m23_mode;
        inhibit[rec_pkg::REC_CH_CBIT] = st_reg.m23_mode;
    end

    // Write-one-to-clear on the sticky register
    assign clr = (wr && addr_ok && idx == rec_pkg::REC_IDX_STICKY) ? wdata : 16'h0000;

    genvar g;
    generate
        for (g = 0; g < rec_pkg::REC_NUM_CHAN; g++) begin : g_chan
            rec_err_chan u_chan (
                .i_clk_sys(i_clk_sys),
                .i_arst_n(i_arst_n),
                .i_clk_en(i_clk_en),
                .i_evt(evt[g]),
                .i_inhibit(inhibit[g]),
                .i_update(i_perf_monitor_update),
                .i_clr_err(clr[rec_pkg::REC_ERR_BASE + g]),
                .i_clr_cnt(clr[rec_pkg::REC_CNT_BASE + g]),
                .o_count(cnt_val[g]),
                .o_err_sticky(err_flag[g]),
                .o_cnt_sticky(cnt_flag[g])
            );
        end
    endgenerate

    assign sticky = {4'h0, err_flag, 4'h0, cnt_flag};

    always_comb begin
        unique case (idx)
            rec_pkg::REC_IDX_CTRL: begin
                rd_word = 16'h0000;
                rd_word[rec_pkg::REC_CTRL_M23_BIT] = st_reg.m23_mode;
                rd_word[rec_pkg::REC_CTRL_CRIT_LSB +: 2] = st_reg.framing_err_criterion;
            end
            rec_pkg::REC_IDX_STICKY: rd_word = sticky;
            rec_pkg::REC_IDX_IRQ_EN: rd_word = st_reg.irq_en;
            rec_pkg::REC_IDX_FRAMING_CNT: rd_word = cnt_val[rec_pkg::REC_CH_FRAMING];
            rec_pkg::REC_IDX_PBIT_CNT: rd_word = cnt_val[rec_pkg::REC_CH_PBIT];
            rec_pkg::REC_IDX_FAR_BLOCK_CNT: rd_word = cnt_val[rec_pkg::REC_CH_FAR_BLOCK];
            rec_pkg::REC_IDX_CBIT_CNT: rd_word = cnt_val[rec_pkg::REC_CH_CBIT];
            default: rd_word = 16'h0000;
        endcase
    end

    always_comb begin
        st_next = st_reg;
        // Read data and error are latched in the setup phase for the access phase
        if (setup) begin
            st_next.prdata = addr_ok ? {16'h0000, rd_word} : 32'h0000_0000;
            st_next.pslverr = !addr_ok;
        end
        if (wr && addr_ok && idx == rec_pkg::REC_IDX_IRQ_EN) begin
            st_next.irq_en = ((st_reg.irq_en & ~wmask) | wdata) & rec_pkg::REC_FLAG_MASK;
        end
        if (wr && addr_ok && idx == rec_pkg::REC_IDX_CTRL) begin
            if (i_pstrb[0]) begin
                st_next.m23_mode = i_pwdata[rec_pkg::REC_CTRL_M23_BIT];
            end
            if (i_pstrb[1]) begin
                st_next.framing_err_criterion = i_pwdata[rec_pkg::REC_CTRL_CRIT_LSB +: 2];
            end
        end
        st_next.irq = (|(sticky & st_reg.irq_en))
            && i_port_status_irq_en_global;
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_reg <= '0;
        end else if (i_clk_en) begin
            st_reg <= st_next;
        end
    end

    assign o_prdata = st_reg.prdata;
    assign o_pslverr = st_reg.pslverr;
    assign o_irq = st_reg.irq;

    a_pbit_err_irq: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_clk_en && sticky[9] && st_reg.irq_en[9] && i_port_status_irq_en_global) |=> o_irq)
        else $error("P-bit error flag did not raise interrupt");
    a_frm_err_irq: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_clk_en && sticky[8] && st_reg.irq_en[8] && i_port_status_irq_en_global) |=> o_irq)
        else $error("framing error flag did not raise interrupt");
    a_cbit_cnt_irq: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_clk_en && sticky[3] && st_reg.irq_en[3] && i_port_status_irq_en_global) |=> o_irq)
        else $error("C-bit count flag did not raise interrupt");
    a_fbe_cnt_irq: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_clk_en && sticky[2] && st_reg.irq_en[2] && i_port_status_irq_en_global) |=> o_irq)
        else $error("far-end count flag did not raise interrupt");
    a_pbit_cnt_irq: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_clk_en && sticky[1] && st_reg.irq_en[1] && i_port_status_irq_en_global) |=> o_irq)
        else $error("P-bit count flag did not raise interrupt");
    a_frm_cnt_irq: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_clk_en && sticky[0] && st_reg.irq_en[0] && i_port_status_irq_en_global) |=> o_irq)
        else $error("framing count flag did not raise interrupt");
    a_irq_gated: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_clk_en && !(i_port_status_irq_en_global && |(sticky & st_reg.irq_en))) |=> !o_irq)
        else $error("interrupt without enabled flag");
    a_count_read: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
        (i_clk_en && setup && i_paddr == {rec_pkg::REC_IDX_FRAMING_CNT, 2'b00})
        |=> o_prdata[15:0] == $past(cnt_val[rec_pkg::REC_CH_FRAMING]))
        else $error("framing count read mismatch");
endmodule // rec_bank

// *** rec_bank_tb.sv ***
// Self-checking testbench for the receive error counter bank.
// Assumes rec_pkg and rec_bank are compiled first; APB master driven on rising edges.
`timescale 1ns/1ns
module rec_bank_tb;
    logic i_clk_sys = 1'b0;
    logic i_arst_n = 1'b0;
    logic i_clk_en = 1'b1;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0000_0000;
    logic [3:0] i_pstrb = 4'hf;
    logic [31:0] o_prdata;
    logic o_pready;
    logic o_pslverr;
    logic [3:0] i_framing_evt = 4'h0;
    logic i_pbit_parity_evt = 1'b0;
    logic i_far_block_evt = 1'b0;
    logic i_cbit_parity_evt = 1'b0;
    logic i_perf_monitor_update = 1'b0;
    logic i_port_status_irq_en_global = 1'b0;
    logic o_irq;
    logic [31:0] rd;
    logic slverr;
    int error_cnt = 0;
    int n_compared = 0;
    int cycles = 0;

    rec_bank rec_bank_i (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_clk_en(i_clk_en),
        .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .i_framing_evt(i_framing_evt),
        .i_pbit_parity_evt(i_pbit_parity_evt), .i_far_block_evt(i_far_block_evt),
        .i_cbit_parity_evt(i_cbit_parity_evt), .i_perf_monitor_update(i_perf_monitor_update),
        .i_port_status_irq_en_global(i_port_status_irq_en_global), .o_irq(o_irq));

    initial begin
        forever #5 i_clk_sys = ~i_clk_sys;
    end

    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge i_clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            error_cnt++;
            $display("wrong value at %0t: run did not finish", $time);
            close_out();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [9:0] idx, input logic [15:0] wd);
        @(posedge i_clk_sys);
        i_psel <= 1'b1;
        i_pwrite <= wr;
        i_paddr <= {idx, 2'b00};
        i_pwdata <= {16'h0000, wd};
        @(posedge i_clk_sys);
        i_penable <= 1'b1;
        do begin
            @(posedge i_clk_sys);
        end while (o_pready !== 1'b1);
        rd = o_prdata;
        slverr = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task automatic rchk(input logic [9:0] idx, input logic [15:0] exp);
        apb(1'b0, idx, 16'h0000);
        chk(rd, {16'h0000, exp}, "register read");
    endtask

    // One-cycle pulses: framing lanes, {cbit, far block, pbit}, update
    task automatic pulse(input logic [3:0] fr, input logic [2:0] cfp, input logic up);
        @(posedge i_clk_sys);
        i_framing_evt <= fr;
        {i_cbit_parity_evt, i_far_block_evt, i_pbit_parity_evt} <= cfp;
        i_perf_monitor_update <= up;
        @(posedge i_clk_sys);
        i_framing_evt <= 4'h0;
        {i_cbit_parity_evt, i_far_block_evt, i_pbit_parity_evt} <= 3'b000;
        i_perf_monitor_update <= 1'b0;
    endtask

    task automatic t_reset();
        rchk(rec_pkg::REC_IDX_FRAMING_CNT, 16'h0000);
        rchk(rec_pkg::REC_IDX_PBIT_CNT, 16'h0000);
        rchk(rec_pkg::REC_IDX_FAR_BLOCK_CNT, 16'h0000);
        rchk(rec_pkg::REC_IDX_CBIT_CNT, 16'h0000);
        rchk(rec_pkg::REC_IDX_IRQ_EN, 16'h0000);
        rchk(rec_pkg::REC_IDX_STICKY, 16'h0000);
        apb(1'b0, 10'h3ff, 16'h0000);
        chk({31'h0, slverr}, 32'h0000_0001, "unmapped error");
        chk(rd, 32'h0000_0000, "unmapped data");
        chk({31'h0, o_pready}, 32'h0000_0001, "ready level");
        $display("test reset done");
    endtask

    task automatic t_count();
        repeat (5) pulse({3'b000, 1'b1}, 3'b111, 1'b0);
        pulse(4'h0, 3'b110, 1'b0);
        pulse(4'h0, 3'b100, 1'b0);
        rchk(rec_pkg::REC_IDX_FRAMING_CNT, 16'h0000);
        pulse(4'h0, 3'b000, 1'b1);
        rchk(rec_pkg::REC_IDX_FRAMING_CNT, 16'h0005);
        rchk(rec_pkg::REC_IDX_PBIT_CNT, 16'h0005);
        rchk(rec_pkg::REC_IDX_FAR_BLOCK_CNT, 16'h0006);
        rchk(rec_pkg::REC_IDX_CBIT_CNT, 16'h0007);
        rchk(rec_pkg::REC_IDX_STICKY, 16'h0f0f);
        pulse(4'h1, 3'b111, 1'b1);
        rchk(rec_pkg::REC_IDX_FRAMING_CNT, 16'h0001);
        rchk(rec_pkg::REC_IDX_CBIT_CNT, 16'h0001);
        $display("test count done");
    endtask

    task automatic t_irq();
        int bits [6] = '{9, 8, 3, 2, 1, 0};
        i_port_status_irq_en_global <= 1'b1;
        repeat (3) @(negedge i_clk_sys);
        chk({31'h0, o_irq}, 32'h0000_0000, "irq with no enable");
        foreach (bits[k]) begin
            apb(1'b1, rec_pkg::REC_IDX_IRQ_EN, 16'h0001 << bits[k]);
            repeat (2) @(negedge i_clk_sys);
            chk({31'h0, o_irq}, 32'h0000_0001, "irq enabled");
            @(posedge i_clk_sys);
            i_port_status_irq_en_global <= 1'b0;
            repeat (3) @(negedge i_clk_sys);
            chk({31'h0, o_irq}, 32'h0000_0000, "irq global off");
            @(posedge i_clk_sys);
            i_port_status_irq_en_global <= 1'b1;
        end
        apb(1'b1, rec_pkg::REC_IDX_IRQ_EN, 16'hffff);
        rchk(rec_pkg::REC_IDX_IRQ_EN, 16'h0f0f);
        apb(1'b1, rec_pkg::REC_IDX_STICKY, 16'h0f0f);
        rchk(rec_pkg::REC_IDX_STICKY, 16'h0000);
        repeat (2) @(negedge i_clk_sys);
        chk({31'h0, o_irq}, 32'h0000_0000, "irq after clear");
        $display("test irq done");
    endtask

    task automatic t_m23();
        apb(1'b1, rec_pkg::REC_IDX_CTRL, 16'h0001);
        repeat (3) pulse(4'h0, 3'b110, 1'b0);
        pulse(4'h0, 3'b001, 1'b1);
        rchk(rec_pkg::REC_IDX_FAR_BLOCK_CNT, 16'h0000);
        rchk(rec_pkg::REC_IDX_CBIT_CNT, 16'h0000);
        rchk(rec_pkg::REC_IDX_PBIT_CNT, 16'h0001);
        rchk(rec_pkg::REC_IDX_STICKY, 16'h0200);
        apb(1'b1, rec_pkg::REC_IDX_CTRL, 16'h0000);
        apb(1'b1, rec_pkg::REC_IDX_STICKY, 16'h0f0f);
        $display("test m23 done");
    endtask

    task automatic t_crit();
        apb(1'b1, rec_pkg::REC_IDX_CTRL, 16'h0100);
        pulse(4'h1, 3'b000, 1'b0);
        rchk(rec_pkg::REC_IDX_STICKY, 16'h0000);
        pulse(4'h2, 3'b000, 1'b0);
        rchk(rec_pkg::REC_IDX_STICKY, 16'h0100);
        pulse(4'h0, 3'b000, 1'b1);
        pulse(4'h2, 3'b000, 1'b0);
        rchk(rec_pkg::REC_IDX_FRAMING_CNT, 16'h0001);
        rchk(rec_pkg::REC_IDX_STICKY, 16'h0101);
        apb(1'b1, rec_pkg::REC_IDX_FRAMING_CNT, 16'h1234);
        rchk(rec_pkg::REC_IDX_FRAMING_CNT, 16'h0001);
        $display("test criterion done");
    endtask

    // Events and an update while the clock enable is low must leave all state alone
    task automatic t_freeze();
        @(posedge i_clk_sys);
        i_clk_en <= 1'b0;
        pulse(4'h2, 3'b111, 1'b1);
        @(posedge i_clk_sys);
        i_clk_en <= 1'b1;
        rchk(rec_pkg::REC_IDX_PBIT_CNT, 16'h0000);
        rchk(rec_pkg::REC_IDX_FRAMING_CNT, 16'h0001);
        rchk(rec_pkg::REC_IDX_STICKY, 16'h0101);
        $display("test freeze done");
    endtask

    initial begin
        repeat (2) @(posedge i_clk_sys);
        i_arst_n <= 1'b1;
        t_reset();
        t_count();
        t_irq();
        t_m23();
        t_crit();
        t_freeze();
        close_out();
    end
endmodule // rec_bank_tb
